// ==== sfr_page_stack_control_tb.sv ====
// Testbench joining the core-side master and the controller; software acts over AXI4-Lite.
// Assumes a command has finished within four cycles after its write response.
`timescale 1ns/1ps
module sfr_page_stack_control_tb;
    import spc_pkg::*;
    logic        aclk, aresetn;
    logic [7:0]  s_awaddr, s_araddr;
    logic [31:0] s_wdata, s_rdata, rd;
    logic [3:0]  s_wstrb;
    logic [1:0]  s_bresp, s_rresp, rsp;
    logic        s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
    logic        s_arvalid, s_arready, s_rvalid, s_rready;
    logic [7:0]  m_pg, m_mid, m_bot;
    logic        m_auto;
    int          n_fail, cmp_count;
    logic [7:0]  addrs [3] = '{SPC_ADDR_PAGE, SPC_ADDR_MIDDLE, SPC_ADDR_BOTTOM};

    spc_if bus_if (.aclk(aclk), .aresetn(aresetn));
    spc_dev u_spc_dev (.aclk(aclk), .aresetn(aresetn), .bus(bus_if.dev));
    spc_core u_spc_core (.aclk(aclk), .aresetn(aresetn), .bus(bus_if.core),
        .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
        .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
        .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
        .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
        .s_rready(s_rready));
    spc_monitor u_spc_monitor (.aclk(aclk), .aresetn(aresetn), .sfr_wr(bus_if.sfr_wr),
        .sfr_rd(bus_if.sfr_rd), .sfr_bit(bus_if.sfr_bit), .sfr_direct(bus_if.sfr_direct),
        .sfr_addr(bus_if.sfr_addr), .sfr_wdata(bus_if.sfr_wdata), .irq_enter(bus_if.irq_enter),
        .irq_return(bus_if.irq_return), .sfr_rdata(bus_if.sfr_rdata), .sfr_hit(bus_if.sfr_hit),
        .sfr_bit_err(bus_if.sfr_bit_err), .page_select(bus_if.page_select),
        .sfr_region(bus_if.sfr_region));

    always #20 aclk = ~aclk;

    task automatic finish_test();
        $display("counts: %0d compares, %0d mismatches", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : finish_test

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : check

    // Each bus task opens with an edge so that no strobe is assigned twice in one step.
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge aclk);
        s_awaddr <= a;
        s_wdata <= d;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (!aw_ok && s_awready) begin
                aw_ok = 1'b1;
                s_awvalid <= 1'b0;
            end
            if (!w_ok && s_wready) begin
                w_ok = 1'b1;
                s_wvalid <= 1'b0;
            end
        end
        while (!s_bvalid) @(posedge aclk);
        r = s_bresp;
        s_bready <= 1'b0;
    endtask : axi_write

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        do @(posedge aclk); while (!s_arready);
        s_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_rvalid);
        d = s_rdata;
        r = s_rresp;
        s_rready <= 1'b0;
    endtask : axi_read

    function automatic logic [7:0] exp_rd(input logic [7:0] a);
        case (a)
            SPC_ADDR_PAGE:    return m_pg;
            SPC_ADDR_MIDDLE:  return m_mid;
            SPC_ADDR_BOTTOM:  return m_bot;
            SPC_ADDR_CONTROL: return (m_pg == SPC_CONTROL_PAGE) ? {7'h00, m_auto} : 8'h00;
            default:          return 8'h00;
        endcase
    endfunction : exp_rd

    function automatic void model(input logic [2:0] c, input logic [7:0] a, input logic [7:0] d);
        if (c == SPC_CMD_WRITE) begin
            if (a == SPC_ADDR_PAGE) m_pg = d;
            if (a == SPC_ADDR_MIDDLE) m_mid = d;
            if (a == SPC_ADDR_BOTTOM) m_bot = d;
            if (a == SPC_ADDR_CONTROL && m_pg == SPC_CONTROL_PAGE) m_auto = d[0];
        end else if (c == SPC_CMD_IRQ && m_auto) begin
            m_bot = m_mid;
            m_mid = m_pg;
        end else if (c == SPC_CMD_RETI && m_auto) begin
            m_pg = m_mid;
            m_mid = m_bot;
            m_bot = 8'h00;
        end
    endfunction : model

    task automatic sfr(input logic [2:0] c, input logic [7:0] a, input logic [7:0] d);
        logic [1:0] r;
        axi_write(SPC_AXI_ADDR, {24'h0, a}, r);
        axi_write(SPC_AXI_WDATA, {24'h0, d}, r);
        axi_write(SPC_AXI_CMD, {29'h0, c}, r);
        check({6'h0, r}, {6'h0, SPC_RESP_OKAY});
        repeat (4) @(posedge aclk);
        model(c, a, d);
        check(bus_if.page_select, m_pg);
    endtask : sfr

    task automatic peek(input logic [7:0] a);
        sfr(SPC_CMD_READ, a, 8'h00);
        axi_read(SPC_AXI_RDATA, rd, rsp);
        check(rd[7:0], exp_rd(a));
    endtask : peek

    task automatic status(input logic [1:0] hit_err);
        axi_read(SPC_AXI_STATUS, rd, rsp);
        check({rd[9:2]}, m_pg);
        check({6'h0, rd[1:0]}, {6'h0, hit_err});
    endtask : status

    initial begin
        repeat (30000) @(posedge aclk);
        n_fail++;
        $display("unexpected at %0t: watchdog expired", $time);
        finish_test();
    end

    initial begin
        {aclk, aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
        {s_awaddr, s_araddr, s_wdata} = '0;
        s_wstrb = 4'h1;
        {m_pg, m_mid, m_bot, m_auto, n_fail, cmp_count} = '0;
        m_auto = 1'b1;
        void'($urandom(32'h2CBF));
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (addrs[i]) peek(addrs[i]);
        sfr(SPC_CMD_WRITE, SPC_ADDR_PAGE, SPC_CONTROL_PAGE);
        peek(SPC_ADDR_CONTROL);
        $display("test reset values done");
        sfr(SPC_CMD_WRITE, SPC_ADDR_CONTROL, 8'hFE);
        peek(SPC_ADDR_CONTROL);
        sfr(SPC_CMD_IRQ, 8'h00, 8'h00);
        sfr(SPC_CMD_WRITE, SPC_ADDR_PAGE, SPC_PAGE_2);
        sfr(SPC_CMD_RETI, 8'h00, 8'h00);
        peek(SPC_ADDR_MIDDLE);
        sfr(SPC_CMD_WRITE, SPC_ADDR_PAGE, SPC_CONTROL_PAGE);
        sfr(SPC_CMD_WRITE, SPC_ADDR_CONTROL, 8'h01);
        sfr(SPC_CMD_WRITE, SPC_ADDR_PAGE, SPC_PAGE_0);
        peek(SPC_ADDR_CONTROL);
        $display("test auto paging off done");
        sfr(SPC_CMD_WRITE, SPC_ADDR_PAGE, SPC_PAGE_2);
        for (int i = 0; i < 3; i++) sfr(SPC_CMD_IRQ, 8'h00, 8'h00);
        peek(SPC_ADDR_BOTTOM);
        sfr(SPC_CMD_WRITE, SPC_ADDR_MIDDLE, 8'h5A);
        for (int i = 0; i < 3; i++) sfr(SPC_CMD_RETI, 8'h00, 8'h00);
        peek(SPC_ADDR_BOTTOM);
        $display("test deep stack done");
        for (int i = 0; i < 60; i++) begin
            case ($urandom_range(0, 4))
                0:       sfr(SPC_CMD_WRITE, addrs[$urandom_range(0, 2)], 8'($urandom));
                1:       sfr(SPC_CMD_IRQ, 8'h00, 8'h00);
                2:       sfr(SPC_CMD_RETI, 8'h00, 8'h00);
                default: peek(addrs[$urandom_range(0, 2)]);
            endcase
        end
        $display("test random stack traffic done");
        sfr(SPC_CMD_BITSET, SPC_ADDR_MIDDLE, 8'h03);
        status(2'b11);
        peek(SPC_ADDR_MIDDLE);
        sfr(SPC_CMD_BITCLR, SPC_ADDR_BOTTOM, 8'h00);
        status(2'b11);
        sfr(SPC_CMD_BITSET, SPC_SFR_LO, 8'h01);
        status(2'b00);
        peek(8'h81);
        status(2'b00);
        peek(SPC_ADDR_BOTTOM);
        status(2'b10);
        sfr(SPC_CMD_READ, 8'h40, 8'h00);
        status(2'b00);
        axi_write(8'h14, 32'h0, rsp);
        check({6'h0, rsp}, {6'h0, SPC_RESP_SLVERR});
        axi_read(8'h14, rd, rsp);
        check({6'h0, rsp}, {6'h0, SPC_RESP_SLVERR});
        $display("test bit and unmapped access done");
        finish_test();
    end
endmodule : sfr_page_stack_control_tb

// ==== spc_core.sv ====
// Core-side master: takes orders over AXI4-Lite and drives the special register bus.
// Assumes software sets the page before paged accesses and in each routine.
`timescale 1ns/1ps
module spc_core (
    input wire logic         aclk,
    input wire logic         aresetn,
    spc_if.core              bus,
    input  wire logic [7:0]  s_awaddr,
    input  wire logic        s_awvalid,
    output logic             s_awready,
    input  wire logic [31:0] s_wdata,
    input  wire logic [3:0]  s_wstrb,
    input  wire logic        s_wvalid,
    output logic             s_wready,
    output logic [1:0]       s_bresp,
    output logic             s_bvalid,
    input  wire logic        s_bready,
    input  wire logic [7:0]  s_araddr,
    input  wire logic        s_arvalid,
    output logic             s_arready,
    output logic [31:0]      s_rdata,
    output logic [1:0]       s_rresp,
    output logic             s_rvalid,
    input  wire logic        s_rready
);
    import spc_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ISSUE = 3'b010,
        ST_WAIT = 3'b100
    } spc_state_t;

    typedef struct packed {
        spc_state_t  st;
        logic        aw_got;
        logic        w_got;
        logic [7:0]  aw_a;
        logic [7:0]  w_d;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic [7:0]  addr;
        logic [7:0]  wd;
        logic [2:0]  cmd;
        logic [7:0]  last;
        logic        err;
        logic        hit;
        logic        wr;
        logic        rd;
        logic        irq;
        logic        reti;
        logic        awready;
        logic        wready;
        logic        arready;
    } spc_core_t;

    spc_core_t c_reg;
    spc_core_t c_next;
    logic      busy;

    assign busy = c_reg.st != ST_IDLE;

    function automatic logic [31:0] rd_mux(input spc_core_t c, input logic [7:0] a);
        unique case (a)
            SPC_AXI_CMD:    return {29'h0, c.cmd};
            SPC_AXI_ADDR:   return {24'h0, c.addr};
            SPC_AXI_WDATA:  return {24'h0, c.wd};
            SPC_AXI_STATUS: return {22'h0, bus.page_select, c.hit, c.err};
            SPC_AXI_RDATA:  return {24'h0, c.last};
            default:        return 32'h0;
        endcase
    endfunction : rd_mux

    always_comb begin
        c_next = c_reg;
        c_next.wr = 1'b0;
        c_next.rd = 1'b0;
        c_next.irq = 1'b0;
        c_next.reti = 1'b0;
        if (s_awvalid && s_awready) begin
            c_next.aw_got = 1'b1;
            c_next.aw_a = s_awaddr;
        end
        if (s_wvalid && s_wready) begin
            c_next.w_got = 1'b1;
            c_next.w_d = s_wstrb[0] ? s_wdata[7:0] : 8'h00;
        end
        if (s_bvalid && s_bready) begin
            c_next.bvalid = 1'b0;
        end
        if (s_rvalid && s_rready) begin
            c_next.rvalid = 1'b0;
        end
        if (c_reg.aw_got && c_reg.w_got && !c_reg.bvalid) begin
            c_next.aw_got = 1'b0;
            c_next.w_got = 1'b0;
            c_next.bvalid = 1'b1;
            c_next.bresp = SPC_RESP_OKAY;
            unique case (c_reg.aw_a)
                SPC_AXI_ADDR:  c_next.addr = c_reg.w_d;
                SPC_AXI_WDATA: c_next.wd = c_reg.w_d;
                SPC_AXI_CMD: begin
                    if (busy) begin
                        c_next.bresp = SPC_RESP_SLVERR;
                    end else begin
                        c_next.cmd = c_reg.w_d[2:0];
                        c_next.st = ST_ISSUE;
                    end
                end
                SPC_AXI_STATUS, SPC_AXI_RDATA: ;
                default: c_next.bresp = SPC_RESP_SLVERR;
            endcase
        end
        if (s_arvalid && s_arready) begin
            c_next.rvalid = 1'b1;
            c_next.rdata = rd_mux(c_reg, s_araddr);
            c_next.rresp = (s_araddr <= SPC_AXI_RDATA && s_araddr[1:0] == 2'h0) ?
                           SPC_RESP_OKAY : SPC_RESP_SLVERR;
        end
        unique case (c_reg.st)
            ST_IDLE: ;
            ST_ISSUE: begin
                c_next.st = ST_WAIT;
                unique case (c_reg.cmd)
                    SPC_CMD_WRITE, SPC_CMD_BITSET, SPC_CMD_BITCLR: c_next.wr = 1'b1;
                    SPC_CMD_READ: c_next.rd = 1'b1;
                    SPC_CMD_IRQ:  c_next.irq = 1'b1;
                    SPC_CMD_RETI: c_next.reti = 1'b1;
                    default:      c_next.st = ST_IDLE;
                endcase
            end
            ST_WAIT: begin
                // The answer is registered on the edge that takes the strobe, so let it pass.
                if (!(c_reg.wr || c_reg.rd || c_reg.irq || c_reg.reti)) begin
                    c_next.st = ST_IDLE;
                    c_next.err = bus.sfr_bit_err;
                    c_next.hit = bus.sfr_hit;
                    if (c_reg.cmd == SPC_CMD_READ) begin
                        c_next.last = bus.sfr_rdata;
                    end
                end
            end
            default: c_next.st = ST_IDLE;
        endcase
        // Readies are registered from the next state so the bus sees flop outputs only.
        c_next.awready = !c_next.aw_got && !c_next.bvalid;
        c_next.wready  = !c_next.w_got && !c_next.bvalid;
        c_next.arready = !c_next.rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            c_reg <= '{st: ST_IDLE, awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0};
        end else begin
            c_reg <= c_next;
        end
    end

    assign s_awready = c_reg.awready;
    assign s_wready  = c_reg.wready;
    assign s_bvalid  = c_reg.bvalid;
    assign s_bresp   = c_reg.bresp;
    assign s_arready = c_reg.arready;
    assign s_rvalid  = c_reg.rvalid;
    assign s_rdata   = c_reg.rdata;
    assign s_rresp   = c_reg.rresp;

    assign bus.sfr_wr      = c_reg.wr;
    assign bus.sfr_rd      = c_reg.rd;
    assign bus.sfr_direct  = 1'b1;
    assign bus.sfr_addr    = c_reg.addr;
    assign bus.sfr_bit     = c_reg.cmd == SPC_CMD_BITSET || c_reg.cmd == SPC_CMD_BITCLR;
    assign bus.sfr_bit_idx = c_reg.wd[2:0];
    assign bus.sfr_bit_val = c_reg.cmd == SPC_CMD_BITSET;
    assign bus.sfr_wdata   = c_reg.wd;
    assign bus.irq_enter   = c_reg.irq;
    assign bus.irq_return  = c_reg.reti;
endmodule : spc_core

// ==== spc_dev.sv ====
// Page stack controller: page select, page stack and page control registers.
// Assumes one bus access per cycle and that irq_enter and irq_return are one-cycle pulses.
// Paged registers of other units are outside; sfr_hit tells the system who answered.
`timescale 1ns/1ps
module spc_dev (
    input wire logic aclk,
    input wire logic aresetn,
    spc_if.dev       bus
);
    import spc_pkg::*;

    typedef struct packed {
        logic       auto_en;
        logic [7:0] rdata;
        logic       hit;
        logic       bit_err;
        logic       region;
    } spc_dev_t;

    spc_dev_t   s_reg;
    spc_dev_t   s_next;
    logic [7:0] page;
    logic [7:0] middle;
    logic [7:0] bottom;
    logic       in_region;
    logic       acc;
    logic       sel_page;
    logic       sel_mid;
    logic       sel_bot;
    logic       sel_ctl;
    logic [7:0] cur;
    logic [7:0] wval;
    logic       push;
    logic       pop;

    assign in_region = bus.sfr_direct && bus.sfr_addr >= SPC_SFR_LO;
    assign acc       = in_region && (bus.sfr_wr || bus.sfr_rd);
    assign sel_page  = bus.sfr_addr == SPC_ADDR_PAGE;
    assign sel_mid   = bus.sfr_addr == SPC_ADDR_MIDDLE;
    assign sel_bot   = bus.sfr_addr == SPC_ADDR_BOTTOM;
    assign sel_ctl   = bus.sfr_addr == SPC_ADDR_CONTROL && page == SPC_CONTROL_PAGE;
    // Pushes are gated by the enable bit only; pops also need irq_enter low.
    assign push      = bus.irq_enter && s_reg.auto_en;
    assign pop       = bus.irq_return && !bus.irq_enter && s_reg.auto_en;

    always_comb begin
        cur = 8'h00;
        if (sel_page) begin
            cur = page;
        end else if (sel_mid) begin
            cur = middle;
        end else if (sel_bot) begin
            cur = bottom;
        end else if (sel_ctl) begin
            cur = {7'h00, s_reg.auto_en};
        end
    end

    // A bit write is a read-modify-write of the addressed byte.
    always_comb begin
        wval = bus.sfr_wdata;
        if (bus.sfr_bit) begin
            wval = cur;
            wval[bus.sfr_bit_idx] = bus.sfr_bit_val;
        end
    end

    spc_stack u_stack (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .push      (push),
        .pop       (pop),
        .wr_page   (acc && bus.sfr_wr && sel_page && s_next.bit_err == 1'b0),
        .wr_middle (acc && bus.sfr_wr && sel_mid && s_next.bit_err == 1'b0),
        .wr_bottom (acc && bus.sfr_wr && sel_bot && s_next.bit_err == 1'b0),
        .wdata     (wval),
        .page      (page),
        .middle    (middle),
        .bottom    (bottom)
    );

    always_comb begin
        s_next = s_reg;
        s_next.region  = in_region;
        s_next.hit     = 1'b0;
        s_next.bit_err = 1'b0;
        if (acc) begin
            s_next.hit = sel_page || sel_mid || sel_bot || sel_ctl;
            // Bit access to a byte-only address is refused and writes nothing.
            s_next.bit_err = bus.sfr_bit && !spc_bit_addressable(bus.sfr_addr);
            if (bus.sfr_rd) begin
                s_next.rdata = cur;
            end
            if (bus.sfr_wr && sel_ctl && !s_next.bit_err) begin
                s_next.auto_en = wval[SPC_AUTO_BIT];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg <= '{auto_en: SPC_AUTO_RST, rdata: 8'h00, hit: 1'b0,
                       bit_err: 1'b0, region: 1'b0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign bus.sfr_rdata   = s_reg.rdata;
    assign bus.sfr_hit     = s_reg.hit;
    assign bus.sfr_bit_err = s_reg.bit_err;
    assign bus.sfr_region  = s_reg.region;
    assign bus.page_select = page;
endmodule : spc_dev

// ==== spc_if.sv ====
// Special register bus between the core-side master and the page stack controller.
// Assumes both ends share aclk and aresetn.
`timescale 1ns/1ps
interface spc_if (
    input wire logic aclk,
    input wire logic aresetn
);
    logic       sfr_wr;
    logic       sfr_rd;
    logic       sfr_bit;
    logic [2:0] sfr_bit_idx;
    logic       sfr_bit_val;
    logic       sfr_direct;
    logic [7:0] sfr_addr;
    logic [7:0] sfr_wdata;
    logic       irq_enter;
    logic       irq_return;
    logic [7:0] sfr_rdata;
    logic       sfr_hit;
    logic       sfr_bit_err;
    logic [7:0] page_select;
    logic       sfr_region;

    modport core (
        output sfr_wr, sfr_rd, sfr_bit, sfr_bit_idx, sfr_bit_val, sfr_direct,
        output sfr_addr, sfr_wdata, irq_enter, irq_return,
        input  sfr_rdata, sfr_hit, sfr_bit_err, page_select, sfr_region
    );
    modport dev (
        input  sfr_wr, sfr_rd, sfr_bit, sfr_bit_idx, sfr_bit_val, sfr_direct,
        input  sfr_addr, sfr_wdata, irq_enter, irq_return,
        output sfr_rdata, sfr_hit, sfr_bit_err, page_select, sfr_region
    );
endinterface : spc_if

// ==== spc_monitor.sv ====
// Checker of the special register bus between the core-side master and the controller.
// Assumes the testbench feeds it the interface signals by name; aclk is the only clock.
`timescale 1ns/1ps
module spc_monitor (
    input wire logic       aclk,
    input wire logic       aresetn,
    input wire logic       sfr_wr,
    input wire logic       sfr_rd,
    input wire logic       sfr_bit,
    input wire logic       sfr_direct,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic       irq_enter,
    input wire logic       irq_return,
    input wire logic [7:0] sfr_rdata,
    input wire logic       sfr_hit,
    input wire logic       sfr_bit_err,
    input wire logic [7:0] page_select,
    input wire logic       sfr_region
);
    import spc_pkg::*;
    logic byte_acc;
    assign byte_acc = sfr_direct && !sfr_bit;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_push;
        irq_enter && !irq_return && !sfr_wr;
    endsequence
    sequence s_page_rd;
        sfr_rd && byte_acc && sfr_addr == SPC_ADDR_PAGE;
    endsequence
    AST_PAGE_WR: assert property (sfr_wr && byte_acc && sfr_addr == SPC_ADDR_PAGE && !irq_return
        |=> page_select == $past(sfr_wdata)) else $error("page write not taken");
    AST_PUSH_HOLD: assert property (s_push |=> $stable(page_select))
        else $error("push changed the page");
    AST_PAGE_CAUSE: assert property ($changed(page_select) |-> $past(sfr_wr || irq_return))
        else $error("page changed without cause");
    AST_READ_PAGE: assert property (s_page_rd |=> sfr_hit && sfr_rdata == $past(page_select))
        else $error("page read wrong");
    AST_BIT_ERR: assert property (sfr_wr && sfr_bit && sfr_direct && sfr_addr >= SPC_SFR_LO
        |=> sfr_bit_err == ($past(sfr_addr[2:0]) != 3'h0)) else $error("bit error flag wrong");
    AST_LOW_MISS: assert property ((sfr_rd || sfr_wr) && sfr_addr < SPC_SFR_LO |=> !sfr_hit)
        else $error("low address hit");
    AST_REGION: assert property ($past(aresetn)
        |-> sfr_region == $past(sfr_direct && sfr_addr >= SPC_SFR_LO)) else $error("region wrong");
    AST_UNMAPPED: assert property (sfr_rd && byte_acc && sfr_addr == 8'h81
        |=> !sfr_hit && sfr_rdata == 8'h00) else $error("unmapped read answered");
    AST_CTRL_RD: assert property (sfr_rd && byte_acc && sfr_addr == SPC_ADDR_CONTROL
        && page_select == SPC_CONTROL_PAGE |=> sfr_hit && sfr_rdata[7:1] == 7'h00)
        else $error("control upper bits not zero");
    AST_COMMON_HIT: assert property (sfr_rd && byte_acc
        && (sfr_addr == SPC_ADDR_MIDDLE || sfr_addr == SPC_ADDR_BOTTOM) |=> sfr_hit)
        else $error("stack entry missed");
endmodule : spc_monitor

// ==== spc_pkg.sv ====
// Constants and functions shared by the page stack controller and the core-side master.
// Assumes one core clock and a synchronous active-low reset on both ends.
package spc_pkg;
    localparam logic [7:0] SPC_SFR_LO       = 8'h80;
    localparam logic [7:0] SPC_SFR_HI       = 8'hFF;
    localparam logic [7:0] SPC_ADDR_PAGE    = 8'hA7;
    localparam logic [7:0] SPC_ADDR_MIDDLE  = 8'h85;
    localparam logic [7:0] SPC_ADDR_BOTTOM  = 8'h86;
    localparam logic [7:0] SPC_ADDR_CONTROL = 8'h8E;
    localparam logic [7:0] SPC_PAGE_0       = 8'h00;
    localparam logic [7:0] SPC_PAGE_2       = 8'h02;
    localparam logic [7:0] SPC_PAGE_F       = 8'h0F;
    localparam logic [7:0] SPC_CONTROL_PAGE = 8'h0F;
    localparam logic [7:0] SPC_PAGE_RST     = 8'h00;
    localparam logic [7:0] SPC_STACK_RST    = 8'h00;
    localparam logic       SPC_AUTO_RST     = 1'b1;
    localparam logic [2:0] SPC_BITADDR_MASK = 3'h0;
    localparam int         SPC_AUTO_BIT     = 0;
    // AXI4-Lite byte offsets of the core-side master's own registers.
    localparam logic [7:0] SPC_AXI_CMD      = 8'h00;
    localparam logic [7:0] SPC_AXI_ADDR     = 8'h04;
    localparam logic [7:0] SPC_AXI_WDATA    = 8'h08;
    localparam logic [7:0] SPC_AXI_STATUS   = 8'h0C;
    localparam logic [7:0] SPC_AXI_RDATA    = 8'h10;
    localparam logic [1:0] SPC_RESP_OKAY    = 2'h0;
    localparam logic [1:0] SPC_RESP_SLVERR  = 2'h2;
    // Command codes written to the command register.
    localparam logic [2:0] SPC_CMD_WRITE    = 3'h1;
    localparam logic [2:0] SPC_CMD_READ     = 3'h2;
    localparam logic [2:0] SPC_CMD_IRQ      = 3'h3;
    localparam logic [2:0] SPC_CMD_RETI     = 3'h4;
    localparam logic [2:0] SPC_CMD_BITSET   = 3'h5;
    localparam logic [2:0] SPC_CMD_BITCLR   = 3'h6;

    // An address is bit-addressable when its low three bits are zero.
    function automatic logic spc_bit_addressable(input logic [7:0] a);
        return a[2:0] == SPC_BITADDR_MASK;
    endfunction : spc_bit_addressable

    // Registers held by this block answer on every page, except page control, which answers only on SPC_CONTROL_PAGE.
    function automatic logic spc_common(input logic [7:0] a);
        return a == SPC_ADDR_PAGE || a == SPC_ADDR_MIDDLE || a == SPC_ADDR_BOTTOM;
    endfunction : spc_common

    function automatic logic spc_page_exists(input logic [7:0] p);
        return p == SPC_PAGE_0 || p == SPC_PAGE_2 || p == SPC_PAGE_F;
    endfunction : spc_page_exists
endpackage : spc_pkg

// ==== spc_stack.sv ====
// Three-entry page stack with software access to each entry.
// Assumes push, pop and writes come from logic on the same clock.
`timescale 1ns/1ps
module spc_stack (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       push,
    input  wire logic       pop,
    input  wire logic       wr_page,
    input  wire logic       wr_middle,
    input  wire logic       wr_bottom,
    input  wire logic [7:0] wdata,
    output logic      [7:0] page,
    output logic      [7:0] middle,
    output logic      [7:0] bottom
);
    import spc_pkg::*;

    typedef struct packed {
        logic [7:0] page;
        logic [7:0] middle;
        logic [7:0] bottom;
    } spc_stack_t;

    spc_stack_t st_reg;
    spc_stack_t st_next;

    always_comb begin
        st_next = st_reg;
        // Plain writes touch one entry only and never move the stack.
        if (wr_page) begin
            st_next.page = wdata;
        end
        if (wr_middle) begin
            st_next.middle = wdata;
        end
        if (wr_bottom) begin
            st_next.bottom = wdata;
        end
        // Hardware movement is applied last so it wins over a same-cycle write to an entry it moves; a push keeps a page write.
        if (push) begin
            st_next.bottom = st_reg.middle;
            st_next.middle = st_reg.page;
        end else if (pop) begin
            st_next.page   = st_reg.middle;
            st_next.middle = st_reg.bottom;
            st_next.bottom = SPC_STACK_RST;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg <= '{page: SPC_PAGE_RST, middle: SPC_STACK_RST, bottom: SPC_STACK_RST};
        end else begin
            st_reg <= st_next;
        end
    end

    assign page   = st_reg.page;
    assign middle = st_reg.middle;
    assign bottom = st_reg.bottom;
endmodule : spc_stack
